/* src/wit_pkg.sv */
// Purpose: shared constants and types of the watch / interval timer
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: printed offsets are register indices, byte address is four times the index
package wit_pkg;

    // system clock
    localparam int unsigned CLK_HZ = 10_000_000;

    // register indices, byte address = index * 4
    localparam logic [31:0] PRSM_IDX = 32'h0FFFF8B0;
    localparam logic [31:0] PRSCM_IDX = 32'h0FFFF8B1;
    localparam logic [31:0] WTM_IDX = 32'hFFFFF680;
    localparam logic [31:0] STAT_IDX = 32'h0FFFF8B2;

    function automatic logic [33:0] wit_byte_addr(input logic [31:0] idx);
        return {idx, 2'b00};
    endfunction

    // reset values and write masks
    localparam logic [7:0] PRSM_RST = 8'h00;
    localparam logic [7:0] PRSCM_RST = 8'h00;
    localparam logic [7:0] WTM_RST = 8'h00;
    localparam logic [7:0] PRSM_WMASK = 8'h13;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // counter widths and tap positions
    localparam int SRC_W = 3;
    localparam int CMP_W = 8;
    localparam int PRE_W = 11;
    localparam int CNT_W = 5;
    localparam int GAP_W = 13;
    localparam int WSRC_TAP = 9;
    localparam int FP_FAST = 1;
    localparam int FP_SHORT = 0;
    localparam logic [PRE_W-1:0] IVL_FULL = 11'h7FF;
    localparam logic [2:0] IVL_MAXK = 3'h7;

    // watch mode register layout
    typedef struct packed {
        logic clock_source_bit;
        logic [2:0] interval_select;
        logic [1:0] flag_period_select;
        logic tick_counter_start_bit;
        logic run_enable_bit;
    } wit_mode_t;

    // prescaler mode register layout
    typedef struct packed {
        logic [2:0] rsv_hi;
        logic main_clock_path_enable;
        logic [1:0] rsv_lo;
        logic [1:0] source_divider_select;
    } wit_psel_t;

    // status word
    typedef struct packed {
        logic [PRE_W-1:0] prescaler;
        logic [CNT_W-1:0] counter;
        logic path_active;
    } wit_stat_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wit_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } wit_rd_state_t;

endpackage

/* src/wit_sync_rise.sv */
// Purpose: three-stage pin synchroniser with rising-edge pulse
// Assumes: pin may change at any time relative to aclk
// Notes: a change counts once stages two and three agree
module wit_sync_rise (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin and edge
    input wire logic pin,
    output logic rise
);
    logic s1_q, s2_q, s3_q, filt_q, rise_q;
    logic filt_d;

    always_comb begin
        filt_d = (s2_q == s3_q) ? s3_q : filt_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            filt_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            rise_q <= filt_d & ~filt_q;
        end
    end

    assign rise = rise_q;
endmodule // wit_sync_rise

/* src/wit_timer.sv */
// Purpose: watch timer with interval function, AXI4-Lite register slave
// Assumes: aclk is the main clock; sub_clock arrives on a pin
// Notes: one-cycle interrupt pulses, no interrupt logic of its own
// Operation
// - source select: undivided, /2, /4, /8
// - compare resets zero; zero means 256
// - count clock is main over 2^(m+1)*N
// - count clock delivered only when path enabled
// - top bit picks clock; k sets interval
// - flag period gives 2^14, 2^13, 2^5, 2^4
// - start bit runs counter, zero clears it
// - run cleared stops and clears both counters
// - watch counting needs start and run
// - start cleared resets only the 5-bit counter
// - ticks repeat at selected periods
// - first watch tick may come early
// - watch mode resets zero, byte access
// - both tick functions share one timer clock
// - counter counts timer clock or its /512
module wit_timer
    import wit_pkg::*;
#(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // subclock pin
    input wire logic sub_clock,
    // tick pulses
    output logic watch_tick_irq,
    output logic interval_tick_irq
);
    import wit_pkg::*;

    localparam logic [33:0] BA_PRSM = wit_byte_addr(PRSM_IDX);
    localparam logic [33:0] BA_PRSCM = wit_byte_addr(PRSCM_IDX);
    localparam logic [33:0] BA_WTM = wit_byte_addr(WTM_IDX);
    localparam logic [33:0] BA_STAT = wit_byte_addr(STAT_IDX);

    // registers and bus state
    wit_psel_t prsm_q, prsm_d;
    logic [CMP_W-1:0] prscm_q, prscm_d;
    wit_mode_t wtm_q, wtm_d;
    wit_wr_state_t wst_q, wst_d;
    wit_rd_state_t rst_q, rst_d;
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // timer state
    logic [SRC_W-1:0] src_q, src_d;
    logic [CMP_W-1:0] div_q, div_d;
    logic half_q, half_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic wirq_q, wirq_d, iirq_q, iirq_d;

    logic sub_rise, path_on, src_en, div_match, brg_en, fw_en, pre512, cnt_src, cnt_full;
    logic counting, wtick, itick;
    logic [SRC_W-1:0] src_mask;
    logic [PRE_W-1:0] ivl_mask;
    wit_stat_t stat;

    wit_sync_rise u_sub (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(sub_clock),
        .rise(sub_rise)
    );

    // main-clock divider chain
    always_comb begin
        path_on = prsm_q.main_clock_path_enable & wtm_q.run_enable_bit;
        src_mask = SRC_W'((4'h1 << prsm_q.source_divider_select) - 4'h1);
        src_en = path_on & ((src_q & src_mask) == src_mask);
        div_match = (div_q == CMP_W'(prscm_q - 8'h01));
        brg_en = src_en & div_match & half_q;
        src_d = path_on ? SRC_W'(src_q + 3'h1) : '0;
        div_d = div_q;
        half_d = half_q;
        if (!path_on) begin
            div_d = '0;
            half_d = 1'b0;
        end else if (src_en) begin
            div_d = div_match ? '0 : CMP_W'(div_q + 8'h01);
            half_d = half_q ^ div_match;
        end
    end

    // watch and interval counting
    always_comb begin
        fw_en = wtm_q.clock_source_bit ? brg_en : sub_rise;
        counting = wtm_q.run_enable_bit & wtm_q.tick_counter_start_bit;
        ivl_mask = PRE_W'(IVL_FULL >> (IVL_MAXK - wtm_q.interval_select));
        itick = fw_en & wtm_q.run_enable_bit & ((pre_q & ivl_mask) == ivl_mask);
        pre512 = fw_en & (&pre_q[WSRC_TAP-1:0]);
        cnt_src = wtm_q.flag_period_select[FP_FAST] ? fw_en : pre512;
        cnt_full = wtm_q.flag_period_select[FP_SHORT] ? (&cnt_q[CNT_W-2:0]) : (&cnt_q);
        wtick = counting & cnt_src & cnt_full;
        pre_d = pre_q;
        if (!wtm_q.run_enable_bit) begin
            pre_d = '0;
        end else if (fw_en) begin
            pre_d = PRE_W'(pre_q + 11'h001);
        end
        cnt_d = cnt_q;
        if (!counting) begin
            cnt_d = '0;
        end else if (cnt_src) begin
            cnt_d = cnt_full ? '0 : CNT_W'(cnt_q + 5'h01);
        end
        wirq_d = wtick;
        iirq_d = itick;
        stat = '{prescaler: pre_q, counter: cnt_q, path_active: path_on};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_q <= '0;
            div_q <= '0;
            half_q <= 1'b0;
            pre_q <= '0;
            cnt_q <= '0;
            wirq_q <= 1'b0;
            iirq_q <= 1'b0;
        end else begin
            src_q <= src_d;
            div_q <= div_d;
            half_q <= half_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            wirq_q <= wirq_d;
            iirq_q <= iirq_d;
        end
    end

    // register slave
    always_comb begin
        prsm_d = prsm_q;
        prscm_d = prscm_q;
        wtm_d = wtm_q;
        wst_d = wst_q;
        rst_d = rst_q;
        aw_held_d = aw_held_q | (s_axi_awvalid & awready_q);
        awaddr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : awaddr_q;
        w_held_d = w_held_q | (s_axi_wvalid & wready_q);
        wbyte_d = (s_axi_wvalid & wready_q) ? s_axi_wdata[7:0] : wbyte_q;
        wlane_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb[0] : wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        case (wst_q)
            WR_IDLE: begin
                if (aw_held_d && w_held_d) begin
                    aw_held_d = 1'b0;
                    w_held_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = RESP_OKAY;
                    wst_d = WR_RESP;
                    if (awaddr_d == BA_PRSM[AW-1:0]) begin
                        if (wlane_d) prsm_d = wit_psel_t'(wbyte_d & PRSM_WMASK);
                    end else if (awaddr_d == BA_PRSCM[AW-1:0]) begin
                        if (wlane_d) prscm_d = wbyte_d;
                    end else if (awaddr_d == BA_WTM[AW-1:0]) begin
                        if (wlane_d) wtm_d = wit_mode_t'(wbyte_d);
                    end else if (awaddr_d != BA_STAT[AW-1:0]) begin
                        bresp_d = RESP_SLVERR;
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wst_d = WR_IDLE;
                end
            end
            default: wst_d = WR_IDLE;
        endcase
        case (rst_q)
            RD_IDLE: begin
                if (s_axi_arvalid && arready_q) begin
                    rvalid_d = 1'b1;
                    rresp_d = RESP_OKAY;
                    rst_d = RD_DATA;
                    if (s_axi_araddr == BA_PRSM[AW-1:0]) begin
                        rdata_d = 32'(prsm_q);
                    end else if (s_axi_araddr == BA_PRSCM[AW-1:0]) begin
                        rdata_d = 32'(prscm_q);
                    end else if (s_axi_araddr == BA_WTM[AW-1:0]) begin
                        rdata_d = 32'(wtm_q);
                    end else if (s_axi_araddr == BA_STAT[AW-1:0]) begin
                        rdata_d = 32'(stat);
                    end else begin
                        rdata_d = '0;
                        rresp_d = RESP_SLVERR;
                    end
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    rvalid_d = 1'b0;
                    rst_d = RD_IDLE;
                end
            end
            default: rst_d = RD_IDLE;
        endcase
        // no new address or data while a response is pending
        awready_d = ~aw_held_d & (wst_d == WR_IDLE);
        wready_d = ~w_held_d & (wst_d == WR_IDLE);
        arready_d = (rst_d == RD_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prsm_q <= wit_psel_t'(PRSM_RST);
            prscm_q <= PRSCM_RST;
            wtm_q <= wit_mode_t'(WTM_RST);
            wst_q <= WR_IDLE;
            rst_q <= RD_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            prsm_q <= prsm_d;
            prscm_q <= prscm_d;
            wtm_q <= wtm_d;
            wst_q <= wst_d;
            rst_q <= rst_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign watch_tick_irq = wirq_q;
    assign interval_tick_irq = iirq_q;

    // checks: count-clock spacing helper
    logic [GAP_W-1:0] gap_q, gap_exp;
    logic seen_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !path_on) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= brg_en ? '0 : GAP_W'(gap_q + 13'h0001);
            seen_q <= seen_q | brg_en;
        end
    end
    always_comb begin
        // widen before the shift; a 2-bit select sum would wrap to zero for select 3
        gap_exp = GAP_W'({4'h0, prscm_q == 8'h00, prscm_q}) << (3'(prsm_q.source_divider_select) + 3'h1);
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_run_rise;
        !wtm_q.run_enable_bit ##1 wtm_q.run_enable_bit;
    endsequence
    sequence s_stopped;
        !wtm_q.run_enable_bit ##1 !wtm_q.run_enable_bit;
    endsequence

    property p_brg_period;
        brg_en && seen_q && $stable(prsm_q) && $stable(prscm_q) |-> gap_q == GAP_W'(gap_exp - 13'h0001);
    endproperty
    a_brg_period: assert property (p_brg_period) else $error("count clock spacing wrong");

    property p_path_gate;
        !prsm_q.main_clock_path_enable |-> !brg_en ##1 (half_q == 1'b0 || prsm_q.main_clock_path_enable);
    endproperty
    a_path_gate: assert property (p_path_gate) else $error("count clock while path off");

    property p_sub_select;
        !wtm_q.clock_source_bit && !sub_rise |=> !interval_tick_irq;
    endproperty
    a_sub_select: assert property (p_sub_select) else $error("interval tick without subclock edge");

    property p_start_clear;
        !wtm_q.tick_counter_start_bit |=> cnt_q == '0 && !watch_tick_irq;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("counter not held clear");

    property p_run_clear;
        s_stopped |=> pre_q == '0 && cnt_q == '0 && !interval_tick_irq;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("counters not cleared when stopped");

    property p_realign;
        wtm_q.run_enable_bit && $past(wtm_q.run_enable_bit) && !wtm_q.tick_counter_start_bit
            |-> pre_q == PRE_W'($past(pre_q) + PRE_W'($past(fw_en)));
    endproperty
    a_realign: assert property (p_realign) else $error("prescaler disturbed by realign");

    property p_restart;
        s_run_rise |-> pre_q == '0 && cnt_q == '0 && src_q == '0 && div_q == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("chain not restarted");

    property p_itick_pulse;
        itick |=> interval_tick_irq ##1 !interval_tick_irq;
    endproperty
    a_itick_pulse: assert property (p_itick_pulse) else $error("interval pulse wrong");

    property p_watch_cause;
        watch_tick_irq |-> $past(cnt_src) && $past(cnt_full) && cnt_q == '0 ##1 !watch_tick_irq;
    endproperty
    a_watch_cause: assert property (p_watch_cause) else $error("watch tick without full count");

    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

endmodule // wit_timer

/* dv/wit_timer_bench.sv */
// Purpose: self-checking bench for the watch / interval timer
// Assumes: AXI4-Lite master tasks, main path fast settings for short runs
// Notes: plain register cases in a table, tick cases by hand after it
module wit_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import wit_pkg::*;

    localparam logic [11:0] adr_psel = {PRSM_IDX[9:0], 2'b00};
    localparam logic [11:0] adr_cmp = {PRSCM_IDX[9:0], 2'b00};
    localparam logic [11:0] adr_wmode = {WTM_IDX[9:0], 2'b00};
    localparam logic [11:0] adr_stat = {STAT_IDX[9:0], 2'b00};
    localparam logic [11:0] adr_none = 12'h100;

    typedef struct packed {
        logic [11:0] adr;
        logic [7:0] wd;
        logic [3:0] strb;
        logic [1:0] bresp;
        logic [31:0] rd;
        logic [1:0] rresp;
    } wit_row_t;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic sub_clock = 1'b0;
    logic sub_en = 1'b0;
    logic [1:0] sub_cnt = 2'h0;
    logic watch_tick_irq;
    logic interval_tick_irq;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    wit_row_t rows [8];

    initial begin
        forever #50 aclk = ~aclk;
    end

    // subclock pin toggles every 4 cycles: one timer clock per 8 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (sub_en) begin
            sub_cnt <= sub_cnt + 2'h1;
            if (sub_cnt == 2'h3) sub_clock <= ~sub_clock;
        end
    end

    wit_timer dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sub_clock(sub_clock), .watch_tick_irq(watch_tick_irq), .interval_tick_irq(interval_tick_irq));

    task automatic results();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        failures++;
        $display("CHECK FAILED at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask

    task automatic endt(input string s);
        $display("test %s done, mismatches so far %0d", s, failures);
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        if (i == 50) hang();
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        if (i == 50) hang();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'h1, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d & m, e);
    endtask

    function automatic logic sel_irq(input bit w);
        return w ? watch_tick_irq : interval_tick_irq;
    endfunction

    task automatic wait_pulse(input bit w, input int bound, output int at);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge aclk);
            #1;
            if (sel_irq(w) === 1'b1) break;
        end
        if (i == bound) hang();
        at = cyc;
        @(posedge aclk);
        #1;
        chk({31'h0, sel_irq(w)}, 32'h0);
    endtask

    task automatic gap(input bit w, input int exp);
        int t0;
        int t1;
        wait_pulse(w, exp + 600, t0);
        wait_pulse(w, exp + 4, t1);
        chk(t1 - t0, exp);
    endtask

    task automatic quiet(input bit w, input int n);
        repeat (n) begin
            @(posedge aclk);
            #1;
            chk({31'h0, sel_irq(w)}, 32'h0);
        end
    endtask

    // divider loaded before the path is enabled, selects changed only while stopped
    task automatic main_path(input logic [1:0] m, input logic [7:0] n, input logic [7:0] mode);
        wr(adr_wmode, 8'h00);
        wr(adr_cmp, n);
        wr(adr_psel, {6'h00, m});
        wr(adr_psel, {6'h04, m});
        wr(adr_wmode, mode);
    endtask

    initial begin
        logic [31:0] d32;
        logic [1:0] r2;
        int k;
        int t0;
        int t1;
        rows = '{'{adr_psel, 8'h03, 4'h1, RESP_OKAY, 32'h03, RESP_OKAY},
                 '{adr_cmp, 8'h5A, 4'h1, RESP_OKAY, 32'h5A, RESP_OKAY},
                 '{adr_cmp, 8'h33, 4'h0, RESP_OKAY, 32'h5A, RESP_OKAY},
                 '{adr_wmode, 8'hA4, 4'h1, RESP_OKAY, 32'hA4, RESP_OKAY},
                 '{adr_wmode, 8'h00, 4'h1, RESP_OKAY, 32'h00, RESP_OKAY},
                 '{adr_stat, 8'hFF, 4'h1, RESP_OKAY, 32'h00, RESP_OKAY},
                 '{adr_none, 8'h12, 4'h1, RESP_SLVERR, 32'h00, RESP_SLVERR},
                 '{adr_psel, 8'h00, 4'h1, RESP_OKAY, 32'h00, RESP_OKAY}};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(adr_psel, 32'hFFFFFFFF, 32'h0);
        rd_chk(adr_cmp, 32'hFFFFFFFF, 32'h0);
        rd_chk(adr_wmode, 32'hFFFFFFFF, 32'h0);
        endt("reset values");
        foreach (rows[j]) begin
            axi_wr(rows[j].adr, rows[j].wd, rows[j].strb, r2);
            chk({30'h0, r2}, {30'h0, rows[j].bresp});
            axi_rd(rows[j].adr, d32, r2);
            chk(d32, rows[j].rd);
            chk({30'h0, r2}, {30'h0, rows[j].rresp});
        end
        endt("register table");
        for (k = 0; k < 4; k++) begin
            main_path(k[1:0], 8'h01, 8'h81);
            gap(1'b0, 16 * (2 << k));
        end
        main_path(2'h1, 8'h03, 8'h81);
        gap(1'b0, 16 * 12);
        main_path(2'h0, 8'h00, 8'h81);
        gap(1'b0, 16 * 512);
        // 10 MHz over 65,536 rounds up to 153, odd, so no halving and m stays 0
        main_path(2'h0, 8'h99, 8'h81);
        gap(1'b0, 16 * 2 * 153);
        endt("count clock divider");
        for (k = 0; k < 8; k++) begin
            main_path(2'h0, 8'h01, {1'b1, k[2:0], 4'h1});
            gap(1'b0, 2 << (4 + k));
        end
        endt("interval select");
        main_path(2'h0, 8'h01, 8'h8F);
        gap(1'b1, 32);
        gap(1'b0, 32);
        main_path(2'h0, 8'h01, 8'h8B);
        gap(1'b1, 64);
        wr(adr_wmode, 8'h89);
        quiet(1'b1, 150);
        gap(1'b0, 32);
        rd_chk(adr_stat, 32'h3E, 32'h0);
        endt("short watch periods");
        // long periods: only the first tick, counted from the run write
        for (k = 0; k < 2; k++) begin
            main_path(2'h0, 8'h01, (k == 0) ? 8'h87 : 8'h83);
            t0 = cyc;
            wait_pulse(1'b1, (16384 << k) + 1200, t1);
            chk({31'h0, (t1 - t0) inside {[(16384 << k) - 4 : (16384 << k) + 1100]}}, 32'h1);
        end
        endt("long watch periods");
        wr(adr_wmode, 8'h00);
        wr(adr_psel, 8'h00);
        wr(adr_wmode, 8'h81);
        quiet(1'b0, 200);
        rd_chk(adr_stat, 32'h1, 32'h0);
        wr(adr_psel, 8'h10);
        gap(1'b0, 32);
        wr(adr_wmode, 8'h83);
        repeat (40) @(posedge aclk);
        wr(adr_wmode, 8'h82);
        quiet(1'b0, 100);
        rd_chk(adr_stat, 32'hFFFFFFFF, 32'h0);
        endt("path enable and stop");
        sub_en <= 1'b1;
        wr(adr_wmode, 8'h00);
        wr(adr_wmode, 8'h0F);
        gap(1'b0, 128);
        gap(1'b1, 128);
        endt("subclock source");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(adr_wmode, 32'hFFFFFFFF, 32'h0);
        quiet(1'b0, 150);
        endt("reset in mid-run");
        results();
    end
endmodule // wit_timer_bench
